/* verilog/tppc_cfg.svh */
// Constants of the tachometer period and phase counter
`ifndef TPPC_CFG_SVH
`define TPPC_CFG_SVH

// ==================================================
// Clock rates and tick timing
`define TPPC_SYS_CLK_MHZ 100
`define TPPC_PER_CLK_MHZ 12
`define TPPC_PH_CLK_MHZ 48
`define TPPC_PER_RES_NS 83
`define TPPC_PH_RES_NS 21
`define TPPC_ACC_W 8

// ==================================================
// Register offsets (byte addresses)
`define TPPC_ADDR_W 8
`define TPPC_OFS_CTRL 8'h00
`define TPPC_OFS_STATUS 8'h04
`define TPPC_OFS_PERLAST 8'h08
`define TPPC_OFS_PHLAST 8'h0c

// ==================================================
// Control field positions
`define TPPC_CTL_PER_FALL 0
`define TPPC_CTL_PER_HOLD 1
`define TPPC_CTL_STALE_EN 2
`define TPPC_CTL_PH_START_LO 4
`define TPPC_CTL_PH_START_HI 5
`define TPPC_CTL_PH_STOP_LO 6
`define TPPC_CTL_PH_STOP_HI 7
`define TPPC_CTL_PH_CLR 8
`define TPPC_CTL_W 9
`define TPPC_CTL_RESET 9'h104

// ==================================================
// Status field positions
`define TPPC_ST_PER_DONE 0
`define TPPC_ST_PER_ARMED 1
`define TPPC_ST_PER_COUNT 2
`define TPPC_ST_PH_DONE 3
`define TPPC_ST_PH_COUNT 4
`define TPPC_ST_W 5

// ==================================================
// Event select codes and channel numbers
`define TPPC_EVT_AD 2'h0
`define TPPC_EVT_RISE 2'h1
`define TPPC_EVT_FALL 2'h2
`define TPPC_CHAN_W 3
`define TPPC_CHAN_PERIOD 3'h4
`define TPPC_CHAN_PHASE 3'h5
`define TPPC_DATA_W 32
`define TPPC_PER_CNT_W 31

`endif

/* verilog/tppc_pkg.sv */
// Types of the tachometer period and phase counter
package tppc_pkg;

  // ==================================================
  // Control register layout
  typedef struct packed {
    logic phClear;
    logic [1:0] phStop;
    logic [1:0] phStart;
    logic pad3;
    logic staleEn;
    logic perHold;
    logic perFall;
  } tppc_ctrl_t;

  // ==================================================
  // Acquisition sample carrier
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } tppc_sample_t;

  // ==================================================
  // State machines
  typedef enum logic [1:0] {
    TPPC_PER_IDLE,
    TPPC_PER_ARM,
    TPPC_PER_COUNT,
    TPPC_PER_DONE
  } tppc_per_state_t;

  typedef enum logic {
    TPPC_PH_WAIT,
    TPPC_PH_COUNT
  } tppc_ph_state_t;

endpackage

/* verilog/tppc_tick_gen.sv */
// Fractional tick generator deriving a slower count rate from clk_sys
`timescale 1ns/10ps
`include "tppc_cfg.svh"

module tppc_tick_gen #(
  parameter logic [`TPPC_ACC_W-1:0] INC = `TPPC_ACC_W'(`TPPC_PER_CLK_MHZ),
  parameter logic [`TPPC_ACC_W-1:0] MODULUS = `TPPC_ACC_W'(`TPPC_SYS_CLK_MHZ)
) (
  input wire logic clk_sys,
  input wire logic reset,
  output logic tick
);

  logic [`TPPC_ACC_W-1:0] acc_r;
  logic [`TPPC_ACC_W:0] accSum;
  logic wrap;

  // ==================================================
  // Phase accumulator: INC ticks per MODULUS clocks
  assign accSum = {1'b0, acc_r} + {1'b0, INC};
  assign wrap = accSum >= {1'b0, MODULUS};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_r <= '0;
      tick <= 1'b0;
    end else begin
      acc_r <= wrap ? (accSum[`TPPC_ACC_W-1:0] - MODULUS) : accSum[`TPPC_ACC_W-1:0];
      tick <= wrap;
    end
  end

endmodule // tppc_tick_gen

/* verilog/tppc_top.sv */
// Tachometer period counter and phase counter with register port
`timescale 1ns/10ps
`include "tppc_cfg.svh"

module tppc_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tachIn,
  input wire logic acqRun,
  input wire logic adSampleDone,
  input wire logic chanReq,
  input wire logic [`TPPC_CHAN_W-1:0] chanNum,
  input wire logic [`TPPC_ADDR_W-1:0] regAddr,
  input wire logic [`TPPC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`TPPC_DATA_W-1:0] regRdData,
  output tppc_pkg::tppc_sample_t sample
);

  // ==================================================
  // Declarations
  tppc_pkg::tppc_ctrl_t ctrl_r;
  tppc_pkg::tppc_per_state_t perState_r;
  tppc_pkg::tppc_per_state_t perState_nxt;
  tppc_pkg::tppc_ph_state_t phState_r;
  tppc_pkg::tppc_ph_state_t phState_nxt;
  logic tachMeta_r;
  logic tachSync_r;
  logic tachPrev_r;
  logic tachRise;
  logic tachFall;
  logic perTick;
  logic phTick;
  logic perEdge;
  logic [`TPPC_PER_CNT_W-1:0] perCnt_r;
  logic [`TPPC_PER_CNT_W-1:0] perCnt_nxt;
  logic [`TPPC_PER_CNT_W-1:0] perLast_r;
  logic [`TPPC_PER_CNT_W-1:0] perCntInc;
  logic perFinish;
  logic perRead;
  logic perFresh;
  logic [`TPPC_PER_CNT_W-1:0] perBody;
  logic perMsb;
  logic [`TPPC_DATA_W-1:0] perValue;
  logic [`TPPC_DATA_W-1:0] phCnt_r;
  logic [`TPPC_DATA_W-1:0] phCnt_nxt;
  logic [`TPPC_DATA_W-1:0] phCntInc;
  logic [`TPPC_DATA_W-1:0] phLast_r;
  logic phDone_r;
  logic phStartEvt;
  logic phStopEvt;
  logic phFinish;
  logic phRead;
  logic [`TPPC_DATA_W-1:0] phValue;
  logic ctrlWrSel;
  logic [`TPPC_ST_W-1:0] status;
  logic [`TPPC_DATA_W-1:0] rdMux;
  tppc_pkg::tppc_sample_t sampleNxt;
  logic perArmed;
  logic perCounting;
  logic perRelaunch;
  logic phCounting;
  logic phStartGo;
  logic rdSelCtrl;
  logic rdSelStatus;
  logic rdSelPerLast;
  logic rdSelPhLast;
  logic [`TPPC_DATA_W-1:0] ctrlWord;
  logic [`TPPC_DATA_W-1:0] statusWord;
  logic [`TPPC_DATA_W-1:0] perLastWord;

  // ==================================================
  // Tachometer pin synchroniser and edge detect
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tachMeta_r <= 1'b0;
      tachSync_r <= 1'b0;
      tachPrev_r <= 1'b0;
    end else begin
      tachMeta_r <= tachIn;
      tachSync_r <= tachMeta_r;
      tachPrev_r <= tachSync_r;
    end
  end

  assign tachRise = tachSync_r & ~tachPrev_r;
  assign tachFall = ~tachSync_r & tachPrev_r;

  // ==================================================
  // Count rate ticks
  // Tick enables keep one clock domain at the cost of one clk_sys of jitter
  // 12 MHz period rate
  tppc_tick_gen #(
    .INC(`TPPC_ACC_W'(`TPPC_PER_CLK_MHZ)),
    .MODULUS(`TPPC_ACC_W'(`TPPC_SYS_CLK_MHZ))
  ) u_perTick (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(perTick)
  );

  tppc_tick_gen #(
    .INC(`TPPC_ACC_W'(`TPPC_PH_CLK_MHZ)),
    .MODULUS(`TPPC_ACC_W'(`TPPC_SYS_CLK_MHZ))
  ) u_phTick (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(phTick)
  );

  // ==================================================
  // Channel decode
  // Channel 4 reads the period counter
  assign perRead = chanReq & (chanNum == `TPPC_CHAN_PERIOD);
  // Channel 5 reads the phase counter
  assign phRead = chanReq & (chanNum == `TPPC_CHAN_PHASE);

  // ==================================================
  // Period measurement
  // Edge polarity select
  assign perEdge = ctrl_r.perFall ? tachFall : tachRise;
  // Counter saturates instead of wrapping on very slow inputs
  assign perCntInc = (&perCnt_r) ? perCnt_r : perCnt_r + `TPPC_PER_CNT_W'(1);
  assign perArmed = perState_r == tppc_pkg::TPPC_PER_ARM;
  assign perCounting = perState_r == tppc_pkg::TPPC_PER_COUNT;
  assign perFresh = perState_r == tppc_pkg::TPPC_PER_DONE;
  assign perFinish = perCounting & perEdge;
  assign perRelaunch = perFresh & perRead;

  always_comb begin
    perState_nxt = perState_r;
    perCnt_nxt = perCnt_r;
    case (perState_r)
      tppc_pkg::TPPC_PER_IDLE: begin
        if (acqRun) begin
          perState_nxt = tppc_pkg::TPPC_PER_ARM;
        end
      end
      tppc_pkg::TPPC_PER_ARM: begin
        // First starting edge opens the count
        if (perEdge) begin
          perState_nxt = tppc_pkg::TPPC_PER_COUNT;
          perCnt_nxt = `TPPC_PER_CNT_W'(1);
        end
      end
      tppc_pkg::TPPC_PER_COUNT: begin
        // Next starting edge closes the count
        if (perEdge) begin
          perState_nxt = tppc_pkg::TPPC_PER_DONE;
        end else if (perTick) begin
          // One count per 12 MHz tick
          perCnt_nxt = perCntInc;
        end
      end
      tppc_pkg::TPPC_PER_DONE: begin
        if (perRelaunch) begin
          perState_nxt = tppc_pkg::TPPC_PER_ARM;
        end
      end
      default: begin
        perState_nxt = tppc_pkg::TPPC_PER_IDLE;
      end
    endcase
    // Dropping acqRun abandons a measurement in progress
    if (!acqRun) begin
      perState_nxt = tppc_pkg::TPPC_PER_IDLE;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      perState_r <= tppc_pkg::TPPC_PER_IDLE;
      perCnt_r <= '0;
    end else begin
      perState_r <= perState_nxt;
      perCnt_r <= perCnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      perLast_r <= '0;
    end else if (perFinish) begin
      perLast_r <= perCnt_r;
    end
  end

  // Zero or last result between measurements
  assign perBody = (perFresh | ctrl_r.perHold) ? perLast_r : '0;
  assign perMsb = ctrl_r.staleEn & ~perFresh;
  assign perValue = {perMsb, perBody};

  // ==================================================
  // Phase measurement
  // Start and stop event select
  assign phStartEvt = (ctrl_r.phStart == `TPPC_EVT_AD) ? adSampleDone :
                      (ctrl_r.phStart == `TPPC_EVT_RISE) ? tachRise :
                      (ctrl_r.phStart == `TPPC_EVT_FALL) ? tachFall : 1'b0;
  assign phStopEvt = (ctrl_r.phStop == `TPPC_EVT_AD) ? adSampleDone :
                     (ctrl_r.phStop == `TPPC_EVT_RISE) ? tachRise :
                     (ctrl_r.phStop == `TPPC_EVT_FALL) ? tachFall : 1'b0;
  // Saturates like the period counter
  assign phCntInc = (&phCnt_r) ? phCnt_r : phCnt_r + `TPPC_DATA_W'(1);
  assign phCounting = phState_r == tppc_pkg::TPPC_PH_COUNT;
  // A start event only counts while acquisition runs
  assign phStartGo = phStartEvt & acqRun;
  assign phFinish = phCounting & phStopEvt;

  always_comb begin
    phState_nxt = phState_r;
    phCnt_nxt = phCnt_r;
    case (phState_r)
      tppc_pkg::TPPC_PH_WAIT: begin
        if (phStartGo) begin
          phState_nxt = tppc_pkg::TPPC_PH_COUNT;
          phCnt_nxt = '0;
        end
      end
      tppc_pkg::TPPC_PH_COUNT: begin
        // Stop event ends the count and does not restart it
        if (phStopEvt) begin
          phState_nxt = tppc_pkg::TPPC_PH_WAIT;
        end else if (phTick) begin
          // One count per 48 MHz tick
          phCnt_nxt = phCntInc;
        end
      end
      default: begin
        phState_nxt = tppc_pkg::TPPC_PH_WAIT;
      end
    endcase
    // Dropping acqRun abandons a timing in progress
    if (!acqRun) begin
      phState_nxt = tppc_pkg::TPPC_PH_WAIT;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phState_r <= tppc_pkg::TPPC_PH_WAIT;
      phCnt_r <= '0;
    end else begin
      phState_r <= phState_nxt;
      phCnt_r <= phCnt_nxt;
    end
  end

  // Latch completed count; a new result beats a read
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phLast_r <= '0;
      phDone_r <= 1'b0;
    end else begin
      if (phFinish) begin
        phLast_r <= phCnt_r;
      end
      phDone_r <= phFinish | (phDone_r & ~phRead);
    end
  end

  assign phValue = (phDone_r | ~ctrl_r.phClear) ? phLast_r : '0;

  // ==================================================
  // Acquisition sample return
  // Served on channel 4 and 5 list requests only, whatever the mode
  assign sampleNxt.valid = perRead | phRead;
  assign sampleNxt.data = perRead ? perValue : (phRead ? phValue : '0);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sample <= '0;
    end else begin
      sample <= sampleNxt;
    end
  end

  // ==================================================
  // Register port
  assign ctrlWrSel = regWr & (regAddr == `TPPC_OFS_CTRL);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= `TPPC_CTL_RESET;
    end else if (ctrlWrSel) begin
      ctrl_r <= regWrData[`TPPC_CTL_W-1:0];
    end
  end

  assign status[`TPPC_ST_PER_DONE] = perFresh;
  assign status[`TPPC_ST_PER_ARMED] = perArmed;
  assign status[`TPPC_ST_PER_COUNT] = perCounting;
  assign status[`TPPC_ST_PH_DONE] = phDone_r;
  assign status[`TPPC_ST_PH_COUNT] = phCounting;

  // Read address decode
  assign rdSelCtrl = regAddr == `TPPC_OFS_CTRL;
  assign rdSelStatus = regAddr == `TPPC_OFS_STATUS;
  assign rdSelPerLast = regAddr == `TPPC_OFS_PERLAST;
  assign rdSelPhLast = regAddr == `TPPC_OFS_PHLAST;

  // Zero-extended read words
  assign ctrlWord = {{(`TPPC_DATA_W-`TPPC_CTL_W){1'b0}}, ctrl_r};
  assign statusWord = {{(`TPPC_DATA_W-`TPPC_ST_W){1'b0}}, status};
  assign perLastWord = {1'b0, perLast_r};

  // Unmapped offsets read as zero; register reads have no side effects
  assign rdMux = rdSelCtrl ? ctrlWord :
                 rdSelStatus ? statusWord :
                 rdSelPerLast ? perLastWord :
                 rdSelPhLast ? phLast_r : '0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= '0;
    end
  end

endmodule // tppc_top

/* verif/tppc_sva.sv */
// Port checker of the tachometer counters
`timescale 1ns/10ps
`include "tppc_cfg.svh"
module tppc_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tachIn,
  input wire logic acqRun,
  input wire logic adSampleDone,
  input wire logic chanReq,
  input wire logic [`TPPC_CHAN_W-1:0] chanNum,
  input wire logic [`TPPC_ADDR_W-1:0] regAddr,
  input wire logic [`TPPC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`TPPC_DATA_W-1:0] regRdData,
  input wire tppc_pkg::tppc_sample_t sample
);
  // ====
  // Control shadow
  logic [8:0] ctrlShadow_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrlShadow_r <= `TPPC_CTL_RESET;
    end else if (regWr && regAddr == `TPPC_OFS_CTRL) begin
      ctrlShadow_r <= regWrData[8:0];
    end
  end
  wire perReq = chanReq && chanNum == `TPPC_CHAN_PERIOD;
  wire tachReq = perReq || (chanReq && chanNum == `TPPC_CHAN_PHASE);
  wire mapped = regAddr[7:4] == 4'h0 && regAddr[1:0] == 2'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data not zero outside read");
  a_rd_unmapped_zero: assert property ($past(regRd) && !$past(mapped) |-> regRdData == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_read_back: assert property ($past(regRd) && $past(regAddr) == `TPPC_OFS_CTRL
    |-> (regRdData & 32'h1f7) == ({23'h0, $past(ctrlShadow_r)} & 32'h1f7))
    else $error("control read back wrong");
  a_status_upper_zero: assert property ($past(regRd) && $past(regAddr) == `TPPC_OFS_STATUS
    |-> regRdData[31:5] == 27'h0) else $error("status upper bits set");
  a_smp_chan_valid: assert property (sample.valid == $past(tachReq))
    else $error("sample valid not tied to channel");
  a_smp_idle_zero: assert property (!sample.valid |-> sample.data == 32'h0)
    else $error("sample data not zero");
  a_per_msb_clear: assert property ($past(perReq) && !$past(ctrlShadow_r[2]) |-> !sample.data[31])
    else $error("period msb set with marking off");
  a_per_stale_zero: assert property ($past(perReq) && $past(ctrlShadow_r[2:1]) == 2'h2 && sample.data[31]
    |-> sample.data[30:0] == 31'h0)
    else $error("stale period value not zero");
endmodule // tppc_sva

bind tppc_top tppc_sva chk (.clk_sys(clk_sys), .reset(reset), .tachIn(tachIn), .acqRun(acqRun),
  .adSampleDone(adSampleDone), .chanReq(chanReq), .chanNum(chanNum), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sample(sample));

/* verif/tppc_partner.sv */
// Tachometer pulse source and A/D sample strobe
`timescale 1ns/10ps
module tppc_partner (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tachEn,
  input wire logic [15:0] hiCyc,
  input wire logic [15:0] loCyc,
  input wire logic adGo,
  output logic tachIn,
  output logic adSampleDone
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= 16'h0001;
      tachIn <= 1'b0;
      adSampleDone <= 1'b0;
    end else begin
      adSampleDone <= adGo;
      if (!tachEn) begin
        cnt_r <= 16'h0001;
        tachIn <= 1'b0;
      end else if (cnt_r >= (tachIn ? hiCyc : loCyc)) begin
        cnt_r <= 16'h0001;
        tachIn <= ~tachIn;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule // tppc_partner

/* verif/tppc_top_tb.sv */
// Self-checking bench of the tachometer counters
`timescale 1ns/10ps
module tppc_top_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic acqRun = 1'b0;
  logic chanReq = 1'b0;
  logic [2:0] chanNum = 3'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic tachEn = 1'b0;
  logic [15:0] hiCyc = 16'h01f4;
  logic [15:0] loCyc = 16'h01f4;
  logic adGo = 1'b0;
  logic tachIn;
  logic adSampleDone;
  logic [31:0] regRdData;
  tppc_pkg::tppc_sample_t sample;
  logic [31:0] d1;
  logic [31:0] d2;
  logic v;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  tppc_top uut (.clk_sys(clk_sys), .reset(reset), .tachIn(tachIn), .acqRun(acqRun),
    .adSampleDone(adSampleDone), .chanReq(chanReq), .chanNum(chanNum), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sample(sample));
  tppc_partner far (.clk_sys(clk_sys), .reset(reset), .tachEn(tachEn), .hiCyc(hiCyc), .loCyc(loCyc),
    .adGo(adGo), .tachIn(tachIn), .adSampleDone(adSampleDone));
  // ====
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %s expected %h to %h seen %h", what, lo, hi, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic smp(input logic [2:0] ch, output logic [31:0] d, output logic ok);
    @(posedge clk_sys);
    chanReq <= 1'b1;
    chanNum <= ch;
    @(posedge clk_sys);
    chanReq <= 1'b0;
    #1 d = sample.data;
    ok = sample.valid;
  endtask
  task automatic ad;
    @(posedge clk_sys);
    adGo <= 1'b1;
    @(posedge clk_sys);
    adGo <= 1'b0;
  endtask
  // ====
  // Scenarios
  task automatic t_regs;
    rd(8'h00, d1);
    chk("ctrl reset", 32'h104, d1);
    rd(8'h04, d1);
    chk("status idle", 32'h0, d1);
    rd(8'h10, d1);
    chk("unmapped", 32'h0, d1);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, d1);
    chk("last ro", 32'h0, d1);
    smp(3'h3, d1, v);
    chk("chan3 valid", 32'h0, {31'h0, v});
  endtask
  task automatic t_period;
    tachEn <= 1'b1;
    cyc(2500);
    smp(3'h4, d1, v);
    chk("not running", 32'h80000000, d1);
    @(posedge clk_sys);
    acqRun <= 1'b1;
    cyc(2500);
    smp(3'h4, d1, v);
    chk("ch4 valid", 32'h1, {31'h0, v});
    rng("count-1", 32'h77, 32'h79, d1 - 32'h1);
    smp(3'h4, d1, v);
    chk("relaunched", 32'h80000000, d1);
    cyc(2100);
    smp(3'h4, d1, v);
    rng("next count", 32'h78, 32'h7a, d1);
  endtask
  task automatic t_hold;
    wr(8'h00, 32'h102);
    cyc(2500);
    smp(3'h4, d1, v);
    rng("hold count", 32'h78, 32'h7a, d1);
    smp(3'h4, d2, v);
    chk("hold last", d1, d2);
  endtask
  task automatic t_fall;
    wr(8'h00, 32'h105);
    hiCyc <= 16'h00c8;
    loCyc <= 16'h0258;
    cyc(2500);
    @(posedge tachIn);
    cyc(10);
    smp(3'h4, d1, v);
    chk("fall fresh", 32'h0, {31'h0, d1[31]});
    cyc(1090);
    smp(3'h4, d1, v);
    rng("fall count", 32'h5f, 32'h63, d1);
  endtask
  task automatic t_phase;
    hiCyc <= 16'h01f4;
    loCyc <= 16'h01f4;
    wr(8'h00, 32'h140);
    @(posedge tachIn);
    cyc(100);
    ad();
    @(posedge tachIn);
    cyc(20);
    smp(3'h5, d1, v);
    chk("ch5 valid", 32'h1, {31'h0, v});
    rng("ad to rise", 32'h1ad, 32'h1b4, d1);
    smp(3'h5, d1, v);
    chk("self clear", 32'h0, d1);
    wr(8'h00, 32'h190);
    @(posedge tachIn);
    @(negedge tachIn);
    cyc(20);
    smp(3'h5, d1, v);
    rng("rise to fall", 32'hee, 32'hf2, d1);
    wr(8'h00, 32'h024);
    @(negedge tachIn);
    cyc(250);
    ad();
    cyc(5);
    smp(3'h5, d1, v);
    rng("fall to ad", 32'h74, 32'h7b, d1);
    smp(3'h5, d2, v);
    chk("keep last", d1, d2);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      $display("MISMATCH timeout expected done seen running");
      results();
    end
  end
  initial begin
    cyc(10);
    reset <= 1'b0;
    t_regs();
    t_period();
    t_hold();
    t_fall();
    t_phase();
    results();
  end
endmodule // tppc_top_tb
